// [verilog/mcu_port_group_io.sv]
// Port group logic: key port, open-drain port, analog input port, two
// segment-shared ports and one interrupt-shared pin, behind an Avalon-MM slave.
// Pins arrive asynchronously and pass two flip-flops; segment data comes from
// the LCD controller on the same clock.
`timescale 1ns/10ps
module mcu_port_group_io
(
  input  wire logic                                 CLOCK_I,
  input  wire logic                                 RST_I,
  input  wire logic [3:0]                           ADDRESS_I,
  input  wire logic                                 READ_I,
  input  wire logic                                 WRITE_I,
  input  wire logic [31:0]                          WRITEDATA_I,
  output logic      [31:0]                          READDATA_O,
  output logic                                      WAITREQUEST_O,
  input  wire logic [port_group_pkg::KEY_W-1:0]     KEYPORT_PIN_I,
  output logic      [port_group_pkg::KEY_W-1:0]     KEYPORT_PIN_O,
  output logic      [port_group_pkg::KEY_W-1:0]     KEYPORT_PIN_OE_O,
  output logic      [port_group_pkg::KEY_W-1:0]     KEYPORT_PULLUP_O,
  output logic      [5:0]                           KEY_RETURN_INPUTS_O,
  input  wire logic [port_group_pkg::OD_W-1:0]      ODPORT_PIN_I,
  output logic      [port_group_pkg::OD_W-1:0]      ODPORT_PIN_O,
  output logic      [port_group_pkg::OD_W-1:0]      ODPORT_PIN_OE_O,
  input  wire logic [port_group_pkg::AN_W-1:0]      ANPORT_PIN_I,
  output logic      [port_group_pkg::AN_W-1:0]      ANALOG_SHARED_O,
  input  wire logic [port_group_pkg::SEGA_W-1:0]    SEGMENT_OUTPUTS_HIGH_I,
  input  wire logic [port_group_pkg::SEGB_W-1:0]    SEGMENT_OUTPUTS_LOW_I,
  input  wire logic [port_group_pkg::SEGA_W-1:0]    SEGA_PIN_I,
  output logic      [port_group_pkg::SEGA_W-1:0]    SEGA_PIN_O,
  output logic      [port_group_pkg::SEGA_W-1:0]    SEGA_PIN_OE_O,
  output logic      [port_group_pkg::SEGA_W-1:0]    SEGA_PULLUP_O,
  input  wire logic [port_group_pkg::SEGB_W-1:0]    SEGB_PIN_I,
  output logic      [port_group_pkg::SEGB_W-1:0]    SEGB_PIN_O,
  output logic      [port_group_pkg::SEGB_W-1:0]    SEGB_PIN_OE_O,
  output logic      [port_group_pkg::SEGB_W-1:0]    SEGB_PULLUP_O,
  input  wire logic                                 INTPIN_I,
  output logic                                      INTPIN_O,
  output logic                                      INTPIN_OE_O,
  output logic                                      EXT_INTERRUPT_IN_O
);
  import port_group_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [KEY_W-1:0]  key_s1, key_s2;
  logic [OD_W-1:0]   od_s1, od_s2;
  logic [AN_W-1:0]   an_s1, an_s2;
  logic [SEGA_W-1:0] sega_s1, sega_s2;
  logic [SEGB_W-1:0] segb_s1, segb_s2;
  logic              int_s1, int_s2, int_s3;

  always_ff @(posedge CLOCK_I)
  begin
    key_s1  <= KEYPORT_PIN_I;
    key_s2  <= key_s1;
    od_s1   <= ODPORT_PIN_I;
    od_s2   <= od_s1;
    an_s1   <= ANPORT_PIN_I;
    an_s2   <= an_s1;
    sega_s1 <= SEGA_PIN_I;
    sega_s2 <= sega_s1;
    segb_s1 <= SEGB_PIN_I;
    segb_s2 <= segb_s1;
    int_s1  <= INTPIN_I;
    int_s2  <= int_s1;
    int_s3  <= int_s2;
  end

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] key_latch, od_latch, sega_latch, segb_latch;
  logic [7:0] key_dir, od_dir, sega_dir, segb_dir;
  logic       int_latch, int_dir, pu_first, key_mode, lcd_sel, int_mask, int_flag;
  logic [5:0] pu_third;
  logic [7:0] next_key_latch, next_od_latch, next_sega_latch, next_segb_latch;
  logic [7:0] next_key_dir, next_od_dir, next_sega_dir, next_segb_dir;
  logic       next_int_latch, next_int_dir, next_pu_first, next_key_mode;
  logic       next_lcd_sel, next_int_mask, next_int_flag;
  logic [5:0] next_pu_third;
  logic       wait_q, next_wait;
  logic [31:0] rdata, next_rdata;
  logic       wr_take, int_edge;
  logic [7:0] wd;
  logic [2:0] bit_sel;

  // The answer comes one cycle after the request is seen, so every access
  // costs exactly two cycles and writes land at a single known edge.
  assign wr_take  = WRITE_I & ~wait_q;
  assign wd       = WRITEDATA_I[7:0];
  assign bit_sel  = WRITEDATA_I[BITOP_BIT_LSB +: 3];
  assign int_edge = int_s2 ^ int_s3;

  function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] pin,
                                           input logic [7:0] latch);
    port_view = (dir & pin) | (~dir & latch); // RULE18
  endfunction

  always_comb
  begin
    next_key_latch  = key_latch;
    next_od_latch   = od_latch;
    next_sega_latch = sega_latch;
    next_segb_latch = segb_latch;
    next_key_dir    = key_dir;
    next_od_dir     = od_dir;
    next_sega_dir   = sega_dir;
    next_segb_dir   = segb_dir;
    next_int_latch  = int_latch;
    next_int_dir    = int_dir;
    next_pu_first   = pu_first;
    next_pu_third   = pu_third;
    next_key_mode   = key_mode;
    next_lcd_sel    = lcd_sel;
    next_int_mask   = int_mask;
    next_int_flag   = int_flag;
    next_wait       = 1'b1;
    next_rdata      = rdata;
    if ((READ_I | WRITE_I) & wait_q)
    begin
      next_wait = 1'b0;
    end
    if (READ_I & wait_q)
    begin
      next_rdata = 32'h0000_0000;
      case (ADDRESS_I)
        REG_KEYPORT:  next_rdata[7:0] = port_view(key_dir, key_s2, key_latch);
        REG_ODPORT:   next_rdata[7:0] = port_view(od_dir, {4'h0, od_s2}, od_latch);
        REG_ANPORT:   next_rdata[6:0] = an_s2; // RULE5
        REG_SEGA:     next_rdata[7:0] = port_view(sega_dir, sega_s2, sega_latch);
        REG_SEGB:     next_rdata[7:0] = port_view(segb_dir, {4'h0, segb_s2}, segb_latch);
        REG_INTPIN:   next_rdata[0]   = int_dir ? int_s2 : int_latch;
        REG_KEY_DIR:  next_rdata[7:0] = key_dir;
        REG_OD_DIR:   next_rdata[3:0] = od_dir[3:0];
        REG_SEGA_DIR: next_rdata[7:0] = sega_dir;
        REG_SEGB_DIR: next_rdata[3:0] = segb_dir[3:0];
        REG_INT_DIR:  next_rdata[0]   = int_dir;
        REG_PU_FIRST: next_rdata[0]   = pu_first;
        REG_PU_THIRD: next_rdata[5:0] = pu_third;
        REG_CONTROL:  next_rdata[2:0] = {int_mask, lcd_sel, key_mode};
        REG_STATUS:   next_rdata[STAT_FLAG_POS] = int_flag;
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
    if (wr_take)
    begin
      case (ADDRESS_I)
        REG_KEYPORT:  next_key_latch = wd;
        REG_ODPORT:   next_od_latch = {4'h0, wd[3:0]};
        REG_SEGA:     next_sega_latch = wd;
        REG_SEGB:     next_segb_latch = {4'h0, wd[3:0]};
        REG_INTPIN:   next_int_latch = wd[0];
        REG_KEY_DIR:  next_key_dir = wd; // RULE11
        REG_OD_DIR:   next_od_dir = {4'hF, wd[3:0]};
        REG_SEGA_DIR: next_sega_dir = wd;
        REG_SEGB_DIR: next_segb_dir = {4'hF, wd[3:0]};
        REG_INT_DIR:  next_int_dir = wd[0];
        REG_BITOP:
        begin
          case (WRITEDATA_I[BITOP_PORT_LSB +: 2]) // RULE11
            2'h0:    next_key_dir[bit_sel] = WRITEDATA_I[BITOP_VAL_POS];
            2'h1:    next_od_dir[bit_sel[1:0]] = WRITEDATA_I[BITOP_VAL_POS];
            2'h2:    next_sega_dir[bit_sel] = WRITEDATA_I[BITOP_VAL_POS];
            default: next_segb_dir[bit_sel[1:0]] = WRITEDATA_I[BITOP_VAL_POS];
          endcase
        end
        REG_PU_FIRST: next_pu_first = wd[0];
        REG_PU_THIRD: next_pu_third = wd[5:0];
        REG_CONTROL:
        begin
          next_key_mode = wd[CTRL_KRM_POS];
          next_lcd_sel  = wd[CTRL_LPS_POS];
          next_int_mask = wd[CTRL_MASK_POS];
        end
        REG_STATUS:   if (wd[STAT_FLAG_POS]) next_int_flag = 1'b0;
        default:      next_rdata = rdata;
      endcase
    end
    // The pin is watched in both directions, so driving a new level out of
    // the latch also raises the flag; a new edge beats a software clear.
    if (int_edge)
    begin
      next_int_flag = 1'b1; // RULE15
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      key_latch  <= LATCH_RESET;
      od_latch   <= LATCH_RESET;
      sega_latch <= LATCH_RESET;
      segb_latch <= LATCH_RESET;
      key_dir    <= DIR_RESET; // RULE12
      od_dir     <= DIR_RESET;
      sega_dir   <= DIR_RESET;
      segb_dir   <= DIR_RESET;
      int_latch  <= 1'b0;
      int_dir    <= 1'b1;
      pu_first   <= 1'b0;
      pu_third   <= 6'h00;
      key_mode   <= 1'b0;
      lcd_sel    <= 1'b0;
      int_mask   <= 1'b1;
      int_flag   <= 1'b0;
      wait_q     <= 1'b1;
      rdata      <= 32'h0000_0000;
    end
    else
    begin
      key_latch  <= next_key_latch;
      od_latch   <= next_od_latch;
      sega_latch <= next_sega_latch;
      segb_latch <= next_segb_latch;
      key_dir    <= next_key_dir;
      od_dir     <= next_od_dir;
      sega_dir   <= next_sega_dir;
      segb_dir   <= next_segb_dir;
      int_latch  <= next_int_latch;
      int_dir    <= next_int_dir;
      pu_first   <= next_pu_first;
      pu_third   <= next_pu_third;
      key_mode   <= next_key_mode;
      lcd_sel    <= next_lcd_sel;
      int_mask   <= next_int_mask;
      int_flag   <= next_int_flag;
      wait_q     <= next_wait;
      rdata      <= next_rdata;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  logic [SEGA_W-1:0] sega_pu_map;
  logic [SEGB_W-1:0] segb_pu_map;

  genvar g;
  generate
    for (g = 0; g < SEGA_W; g++)
    begin : g_sega_pairs
      assign sega_pu_map[g] = pu_third[g / 2]; // RULE6
    end
    for (g = 0; g < SEGB_W; g++)
    begin : g_segb_pairs
      assign segb_pu_map[g] = pu_third[PU3_SEGB_LSB + g / 2]; // RULE8
    end
  endgenerate

  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      KEYPORT_PIN_O       <= '0; // RULE10
      KEYPORT_PIN_OE_O    <= '0;
      KEYPORT_PULLUP_O    <= '0;
      KEY_RETURN_INPUTS_O <= '0;
      ODPORT_PIN_O        <= '0;
      ODPORT_PIN_OE_O     <= '0;
      ANALOG_SHARED_O     <= '0;
      SEGA_PIN_O          <= '0;
      SEGA_PIN_OE_O       <= '0;
      SEGA_PULLUP_O       <= '0;
      SEGB_PIN_O          <= '0;
      SEGB_PIN_OE_O       <= '0;
      SEGB_PULLUP_O       <= '0;
      INTPIN_O            <= 1'b0;
      INTPIN_OE_O         <= 1'b0;
      EXT_INTERRUPT_IN_O  <= 1'b0;
    end
    else
    begin
      KEYPORT_PIN_O       <= key_latch; // RULE1
      KEYPORT_PIN_OE_O    <= ~key_dir; // RULE17
      KEYPORT_PULLUP_O    <= key_dir & {KEY_W{pu_first}}; // RULE2
      KEY_RETURN_INPUTS_O <= key_s2[5:0] & key_dir[5:0] & {6{key_mode}}; // RULE3
      ODPORT_PIN_O        <= '0; // RULE4
      ODPORT_PIN_OE_O     <= ~od_dir[3:0] & ~od_latch[3:0];
      ANALOG_SHARED_O     <= an_s2; // RULE5
      SEGA_PIN_O          <= lcd_sel ? SEGMENT_OUTPUTS_HIGH_I : sega_latch; // RULE7
      SEGA_PIN_OE_O       <= ~sega_dir; // RULE6
      SEGA_PULLUP_O       <= sega_dir & sega_pu_map;
      SEGB_PIN_O          <= lcd_sel ? SEGMENT_OUTPUTS_LOW_I : segb_latch[3:0]; // RULE9
      SEGB_PIN_OE_O       <= ~segb_dir[3:0]; // RULE8
      SEGB_PULLUP_O       <= segb_dir[3:0] & segb_pu_map;
      INTPIN_O            <= int_latch;
      INTPIN_OE_O         <= ~int_dir; // RULE17
      EXT_INTERRUPT_IN_O  <= int_flag & ~int_mask;
    end
  end

  assign READDATA_O    = rdata;
  assign WAITREQUEST_O = wait_q;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_key_dir_write;
    WRITE_I && !wait_q && ADDRESS_I == REG_KEY_DIR;
  endsequence

  sequence s_req_seen;
    (READ_I || WRITE_I) && wait_q;
  endsequence

  a_reset_dirs: assert property (@(posedge CLOCK_I) RST_I |=> key_dir == DIR_RESET // RULE12
    && sega_dir == DIR_RESET && od_dir == DIR_RESET && segb_dir == DIR_RESET)
    else $error("Direction registers not all ones after reset.");
  a_reset_inputs: assert property (@(posedge CLOCK_I) RST_I ##1 RST_I |=> // RULE10
    KEYPORT_PIN_OE_O == '0 && SEGA_PIN_OE_O == '0 && ODPORT_PIN_OE_O == '0)
    else $error("A driver is enabled after reset.");
  a_bus_answer: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_req_seen |=> !WAITREQUEST_O ##1 WAITREQUEST_O)
    else $error("Bus answer not a single cycle after the request.");
  a_dir_byte: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE11
    s_key_dir_write |=> key_dir == $past(WRITEDATA_I[7:0]))
    else $error("Direction byte write lost.");
  a_key_drive: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE17
    s_key_dir_write ##1 1'b1 |=> KEYPORT_PIN_OE_O == ~$past(WRITEDATA_I[7:0], 2))
    else $error("Key port enables do not follow the direction write.");
  a_od_lowonly: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE4
    ODPORT_PIN_OE_O != '0 |-> ODPORT_PIN_O == '0 && $past(od_latch[3:0]) != 4'hF)
    else $error("Open-drain port drives high or drives with latch all ones.");
  a_flag_edge: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE15
    $changed(int_s2) |=> int_flag)
    else $error("Level change on interrupt pin did not set the flag.");
  a_seg_select: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE7
    lcd_sel && $stable(lcd_sel) |=> SEGA_PIN_O == $past(SEGMENT_OUTPUTS_HIGH_I))
    else $error("Segment port A does not carry segment drive.");
  a_key_pullup: assert property (@(posedge CLOCK_I) disable iff (RST_I) // RULE2
    !pu_first |=> KEYPORT_PULLUP_O == '0)
    else $error("Key port pull-up active with option bit clear.");
endmodule // mcu_port_group_io

// [inc/port_group_pkg.sv]
// Constants for the port group block: register indices, field positions,
// reset values and widths.
// Assumes a 32-bit Avalon-MM slave with word addressing (index = word).
// Functional notes
// [RULE1] Key port: 8-bit bidirectional, output latch, per-bit direction register.
// [RULE2] One bit of first pull-up option enables all key port input pull-ups.
// [RULE3] Key port doubles as key-return inputs once key-return mode is set.
// [RULE4] Open-drain port: 4 bits, pulls low only, latch and per-bit direction.
// [RULE5] Analog port: 7-bit input only, also feeds converter and comparator.
// [RULE6] Segment port A: 8-bit bidirectional; pull-ups enabled per pin pair.
// [RULE7] Segment port A pins may carry LCD segment drive, chosen by selector.
// [RULE8] Segment port B: 4-bit bidirectional; pull-ups enabled per pin pair.
// [RULE9] Segment port B pins may carry LCD segment drive, same selector.
// [RULE10] Reset puts every port in input mode with drivers off.
// [RULE11] Direction registers take single-bit updates and whole-byte writes.
// [RULE12] Reset loads every direction register with all ones.
// [RULE13] Software clears direction and latch bits before output alternate use.
// [RULE14] Software sets direction ones and key-return mode before key-return use.
// [RULE15] Level change on interrupt-shared pin in output mode sets request flag.
// [RULE16] Software should mask the interrupt before driving the shared pin.
// [RULE17] Direction one means input; zero drives the pin from the latch.
// [RULE18] Port read gives pin level for inputs and latch for outputs.
package port_group_pkg;
  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [3:0] REG_KEYPORT   = 4'h0;
  localparam logic [3:0] REG_ODPORT    = 4'h1;
  localparam logic [3:0] REG_ANPORT    = 4'h2;
  localparam logic [3:0] REG_SEGA      = 4'h3;
  localparam logic [3:0] REG_SEGB      = 4'h4;
  localparam logic [3:0] REG_INTPIN    = 4'h5;
  localparam logic [3:0] REG_KEY_DIR   = 4'h6;
  localparam logic [3:0] REG_OD_DIR    = 4'h7;
  localparam logic [3:0] REG_SEGA_DIR  = 4'h8;
  localparam logic [3:0] REG_SEGB_DIR  = 4'h9;
  localparam logic [3:0] REG_BITOP     = 4'hA;
  localparam logic [3:0] REG_INT_DIR   = 4'hB;
  localparam logic [3:0] REG_PU_FIRST  = 4'hC;
  localparam logic [3:0] REG_PU_THIRD  = 4'hD;
  localparam logic [3:0] REG_CONTROL   = 4'hE;
  localparam logic [3:0] REG_STATUS    = 4'hF;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BITOP_PORT_LSB = 0;
  localparam int BITOP_BIT_LSB  = 2;
  localparam int BITOP_VAL_POS  = 8;
  localparam int CTRL_KRM_POS   = 0;
  localparam int CTRL_LPS_POS   = 1;
  localparam int CTRL_MASK_POS  = 2;
  localparam int STAT_FLAG_POS  = 0;
  localparam int PU3_SEGB_LSB   = 4;
  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int KEY_W  = 8;
  localparam int OD_W   = 4;
  localparam int AN_W   = 7;
  localparam int SEGA_W = 8;
  localparam int SEGB_W = 4;
  localparam logic [7:0] DIR_RESET   = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;
endpackage

// [verification/pin_world.sv]
// Far side of the port group: key, open-drain, segment and interrupt pins, pull-ups and outside sources.
// Assumes the bench sets which bits an outside source drives and to what level.
`timescale 1ns/10ps
module pin_world
(
  input  wire logic       clock_i,
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_v_i,
  input  wire logic [7:0] key_oe_i,
  input  wire logic [7:0] key_o_i,
  input  wire logic [7:0] key_pu_i,
  input  wire logic [3:0] od_oe_i,
  input  wire logic [7:0] sa_oe_i,
  input  wire logic [7:0] sa_o_i,
  input  wire logic [7:0] sa_pu_i,
  input  wire logic [3:0] sb_oe_i,
  input  wire logic [3:0] sb_o_i,
  input  wire logic [3:0] sb_pu_i,
  input  wire logic       int_oe_i,
  input  wire logic       int_o_i,
  output logic      [7:0] key_pin_o,
  output logic      [3:0] od_pin_o,
  output logic      [7:0] sa_pin_o,
  output logic      [3:0] sb_pin_o,
  output logic            int_pin_o
);
  logic tog = 1'b0;
  always @(posedge clock_i) tog <= ~tog;
  // A floating pin without pull-up toggles, so a stale value never passes.
  function automatic logic [7:0] lvl(input logic [7:0] oe, o, pu, en, v, input logic t);
    for (int i = 0; i < 8; i++)
      lvl[i] = oe[i] ? o[i] : en[i] ? v[i] : pu[i] ? 1'b1 : t ^ i[0];
  endfunction
  assign key_pin_o = lvl(key_oe_i, key_o_i, key_pu_i, ext_en_i, ext_v_i, tog);
  assign od_pin_o  = 4'(lvl({4'h0, od_oe_i}, 8'h00, 8'h00, ext_en_i, ext_v_i, tog));
  assign sa_pin_o  = lvl(sa_oe_i, sa_o_i, sa_pu_i, ext_en_i, ext_v_i, tog);
  assign sb_pin_o  = 4'(lvl({4'h0, sb_oe_i}, {4'h0, sb_o_i}, {4'h0, sb_pu_i}, ext_en_i,
                         ext_v_i, tog));
  assign int_pin_o = 1'(lvl({7'h0, int_oe_i}, {7'h0, int_o_i}, 8'h00, ext_en_i, ext_v_i, tog));
endmodule // pin_world

// [verification/mcu_port_group_io_bench.sv]
// Self-checking bench for the port group, driving its Avalon-MM slave.
// Assumes the package constants and one answer cycle per bus request.
`timescale 1ns/10ps
module mcu_port_group_io_bench;
  import port_group_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic [3:0]  adr = 4'h0, seg_lo = 4'h0;
  logic [31:0] wd = 32'h0, rdat, got;
  logic        wreq, int_o, int_oe, int_i, irq;
  logic [7:0]  key_i, key_o, key_oe, key_pu, sa_i, sa_o, sa_oe, sa_pu, seg_hi = 8'h00;
  logic [7:0]  ext_en = 8'hFF, ext_v = 8'h3C;
  logic [5:0]  kr;
  logic [3:0]  od_i, od_o, od_oe, sb_i, sb_o, sb_oe, sb_pu;
  logic [6:0]  an_i = 7'h55, an_o;
  int          n_fail = 0, cmp_count = 0, cyc = 0;
  always #2 clk = ~clk;
  mcu_port_group_io DUT (.CLOCK_I(clk), .RST_I(rst), .ADDRESS_I(adr), .READ_I(rd),
    .WRITE_I(wr), .WRITEDATA_I(wd), .READDATA_O(rdat), .WAITREQUEST_O(wreq),
    .KEYPORT_PIN_I(key_i), .KEYPORT_PIN_O(key_o), .KEYPORT_PIN_OE_O(key_oe),
    .KEYPORT_PULLUP_O(key_pu), .KEY_RETURN_INPUTS_O(kr), .ODPORT_PIN_I(od_i),
    .ODPORT_PIN_O(od_o), .ODPORT_PIN_OE_O(od_oe), .ANPORT_PIN_I(an_i),
    .ANALOG_SHARED_O(an_o), .SEGMENT_OUTPUTS_HIGH_I(seg_hi),
    .SEGMENT_OUTPUTS_LOW_I(seg_lo), .SEGA_PIN_I(sa_i), .SEGA_PIN_O(sa_o),
    .SEGA_PIN_OE_O(sa_oe), .SEGA_PULLUP_O(sa_pu), .SEGB_PIN_I(sb_i), .SEGB_PIN_O(sb_o),
    .SEGB_PIN_OE_O(sb_oe), .SEGB_PULLUP_O(sb_pu), .INTPIN_I(int_i), .INTPIN_O(int_o),
    .INTPIN_OE_O(int_oe), .EXT_INTERRUPT_IN_O(irq));
  pin_world far (.clock_i(clk), .ext_en_i(ext_en), .ext_v_i(ext_v), .key_oe_i(key_oe),
    .key_o_i(key_o), .key_pu_i(key_pu), .od_oe_i(od_oe), .sa_oe_i(sa_oe), .sa_o_i(sa_o),
    .sa_pu_i(sa_pu), .sb_oe_i(sb_oe), .sb_o_i(sb_o), .sb_pu_i(sb_pu), .int_oe_i(int_oe),
    .int_o_i(int_o), .key_pin_o(key_i), .od_pin_o(od_i), .sa_pin_o(sa_i), .sb_pin_o(sb_i),
    .int_pin_o(int_i));
  // ********************************
  // Shared tasks
  // ********************************
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      give_verdict;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Called just after a rising edge; returns one edge after the answer edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    do
    begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20)
      chk("bus answer", 32'h0, 32'h1);
    got = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), exp, got);
  endtask
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_reset;
    rd_chk(REG_KEY_DIR, 32'hFF);
    rd_chk(REG_OD_DIR, 32'h0F);
    rd_chk(REG_SEGA_DIR, 32'hFF);
    rd_chk(REG_SEGB_DIR, 32'h0F);
    rd_chk(REG_INT_DIR, 32'h01);
    rd_chk(REG_BITOP, 32'h0);
  endtask
  task automatic t_key;
    bus(1'b1, REG_KEYPORT, 32'hA5);
    bus(1'b1, REG_KEY_DIR, 32'h0F);
    bus(1'b1, REG_PU_FIRST, 32'h1);
    settle;
    chk("key oe", 32'hF0, key_oe);
    chk("key out", 32'hA5, key_o);
    chk("key pullup", 32'h0F, key_pu);
    rd_chk(REG_KEYPORT, 32'hAC);
    bus(1'b1, REG_BITOP, 32'h0C);
    rd_chk(REG_KEY_DIR, 32'h07);
    bus(1'b1, REG_BITOP, 32'h118);
    rd_chk(REG_KEY_DIR, 32'h47);
    bus(1'b1, REG_KEY_DIR, 32'hFF);
    bus(1'b1, REG_PU_FIRST, 32'h0);
    bus(1'b1, REG_CONTROL, 32'h5);
    settle;
    chk("key return", 32'h3C, kr);
    chk("key pullup off", 32'h0, key_pu);
  endtask
  task automatic t_od_an;
    bus(1'b1, REG_ODPORT, 32'h5);
    bus(1'b1, REG_OD_DIR, 32'h0);
    bus(1'b1, REG_ANPORT, 32'h0);
    settle;
    chk("od oe", 32'hA, od_oe);
    chk("od out", 32'h0, od_o);
    rd_chk(REG_ODPORT, 32'h5);
    bus(1'b1, REG_BITOP, 32'h101);
    rd_chk(REG_OD_DIR, 32'h1);
    rd_chk(REG_ODPORT, 32'h4);
    chk("analog", 32'h55, an_o);
    rd_chk(REG_ANPORT, 32'h55);
    an_i <= 7'h2A;
    settle;
    chk("analog new", 32'h2A, an_o);
  endtask
  task automatic t_seg;
    bus(1'b1, REG_PU_THIRD, 32'h15);
    settle;
    chk("seg a pullup", 32'h33, sa_pu);
    chk("seg b pullup", 32'h3, sb_pu);
    bus(1'b1, REG_SEGA, 32'h81);
    bus(1'b1, REG_SEGA_DIR, 32'h0);
    bus(1'b1, REG_SEGB_DIR, 32'h0);
    settle;
    chk("seg a out", 32'h81, sa_o);
    chk("seg b oe", 32'hF, sb_oe);
    bus(1'b1, REG_BITOP, 32'h11E);
    rd_chk(REG_SEGA_DIR, 32'h80);
    bus(1'b1, REG_BITOP, 32'h10B);
    rd_chk(REG_SEGB_DIR, 32'h04);
    bus(1'b1, REG_SEGA, 32'h0);
    seg_hi <= 8'hC3;
    seg_lo <= 4'h6;
    bus(1'b1, REG_CONTROL, 32'h6);
    settle;
    chk("seg a lcd", 32'hC3, sa_o);
    chk("seg b lcd", 32'h6, sb_o);
    chk("seg a oe", 32'h7F, sa_oe);
    rd_chk(REG_CONTROL, 32'h6);
    rd_chk(REG_PU_THIRD, 32'h15);
  endtask
  task automatic t_int;
    bus(1'b1, REG_INT_DIR, 32'h0);
    settle;
    bus(1'b1, REG_STATUS, 32'h1);
    bus(1'b1, REG_CONTROL, 32'h0);
    settle;
    chk("irq idle", 32'h0, irq);
    bus(1'b1, REG_INTPIN, 32'h1);
    settle;
    rd_chk(REG_STATUS, 32'h1);
    chk("int drive", 32'h3, {int_oe, int_o});
    chk("irq out", 32'h1, irq);
    bus(1'b1, REG_CONTROL, 32'h4);
    settle;
    chk("irq masked", 32'h0, irq);
    bus(1'b1, REG_STATUS, 32'h1);
    rd_chk(REG_STATUS, 32'h0);
  endtask
  // A second reset with drivers enabled must turn them all off again.
  task automatic t_rerun;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("rerun oe", 32'h0, {key_oe, sa_oe, od_oe, sb_oe, int_oe});
    rst <= 1'b0;
    t_reset;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    chk("reset oe", 32'h0, {key_oe, sa_oe, od_oe, sb_oe, int_oe});
    chk("reset wait", 32'h1, wreq);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_key;
    t_od_an;
    t_seg;
    t_int;
    t_rerun;
    give_verdict;
  end
endmodule // mcu_port_group_io_bench
